/* File: dv/spk_remote_node.sv */
// Remote serial node model that drives the data pin and samples the port's serial outputs.
`timescale 1ns/1ns
module spk_remote_node (
	input  wire logic ref_clk,
	input  wire logic txd_o,
	input  wire logic rxd_o,
	input  wire logic rxd_oe,
	output logic      line_o
);
	// The pin idles at its pull-up level whenever the node is not sending.
	initial line_o = 1'b1;

	// Bounded wait for the serial output to reach a level; ok drops on timeout so a hang is reported.
	task automatic wait_lvl(input logic lvl, inout bit ok);
		for (int n = 0; n < 2000 && txd_o !== lvl; n++) begin
			@(posedge ref_clk);
			#1;
		end
		if (txd_o !== lvl)
			ok = 1'b0;
	endtask : wait_lvl

	// Sends one frame of eleven bit times, start bit first, then one idle bit time.
	task automatic send(input logic [10:0] bits, input int cpb);
		for (int i = 0; i < 12; i++) begin
			@(posedge ref_clk);
			line_o <= (i < 11) ? bits[i] : 1'b1;
			repeat (cpb - 1) @(posedge ref_clk);
		end
	endtask : send

	// Samples eleven bit times at their centres, starting from the falling start edge.
	task automatic grab(input int cpb, output logic [10:0] bits, output bit ok);
		ok = 1'b1;
		wait_lvl(1'b0, ok);
		for (int i = 0; i < 11; i++) begin
			repeat ((i == 0) ? cpb / 2 : cpb) @(posedge ref_clk);
			#1;
			bits[i] = txd_o;
		end
	endtask : grab

	// Takes a shift-mode byte in every high phase of the shift clock; an undriven pin reads unknown.
	task automatic m0_grab(output logic [7:0] dat, output bit ok);
		ok = 1'b1;
		wait_lvl(1'b0, ok);
		for (int i = 0; i < 8; i++) begin
			wait_lvl(1'b1, ok);
			dat[i] = (rxd_oe === 1'b1) ? rxd_o : 1'bx;
			if (i < 7)
				wait_lvl(1'b0, ok);
		end
	endtask : m0_grab

	// Presents each bit during the low phase so it is stable through the sampling high phase.
	task automatic m0_send(input logic [7:0] dat, output bit ok);
		ok = 1'b1;
		wait_lvl(1'b0, ok);
		for (int i = 0; i < 8; i++) begin
			line_o <= dat[i];
			wait_lvl(1'b1, ok);
			if (i < 7)
				wait_lvl(1'b0, ok);
		end
		@(posedge ref_clk);
		line_o <= 1'b1;
	endtask : m0_send
endmodule : spk_remote_node

/* File: dv/spk_serial_port_tb.sv */
// Self-checking bench for the four-mode serial port against a behavioural model.
`timescale 1ns/1ns
module spk_serial_port_tb;
	logic                 ref_clk = 1'b0;
	logic                 srst    = 1'b1;
	logic                 t1_ovf  = 1'b0;
	spk_pkg::spk_bus_type bus     = '0;
	logic [7:0]           rdata;
	logic                 rxd_i;
	logic                 rxd_o;
	logic                 rxd_oe;
	logic                 txd_o;
	logic                 line;
	logic [7:0]           d;
	logic [7:0]           v;
	logic [10:0]          bits;
	bit                   ok;
	int                   mismatches = 0;
	int                   n_compared = 0;
	int                   seed       = 32'h0e56ca2d;
	int                   mode = 0, filt = 0, ren = 0, tb8 = 0;
	int                   m_ri = 0, m_ti = 0, m_rb8 = 0, m_fe = 0;
	int                   q_rx[$];
	// Receive cases: mode, filter, enable, ninth bit, stop bit, fast rate, keep the done flags set.
	int                   tab[8][7] = '{'{1, 0, 1, 0, 1, 0, 0}, '{1, 1, 1, 0, 0, 0, 0}, '{1, 0, 0, 0, 1, 0, 0},
		'{3, 1, 1, 0, 1, 0, 0}, '{3, 1, 1, 1, 1, 0, 0}, '{2, 0, 1, 0, 0, 1, 0}, '{2, 0, 1, 1, 1, 1, 1},
		'{2, 0, 1, 1, 1, 0, 0}};

	// Clock at 4 ns; the overflow pulse every other cycle gives 32 cycles a bit in modes 1 and 3.
	always #2 ref_clk = ~ref_clk;
	always @(posedge ref_clk) t1_ovf <= ~t1_ovf;
	// The data pin carries the port's drive in shift transmit, else the remote node or its pull-up.
	assign rxd_i = rxd_oe ? rxd_o : line;

	spk_serial_port i_spk_serial_port (
		.ref_clk (ref_clk),
		.srst    (srst),
		.bus     (bus),
		.rdata   (rdata),
		.t1_ovf  (t1_ovf),
		.rxd_i   (rxd_i),
		.rxd_o   (rxd_o),
		.rxd_oe  (rxd_oe),
		.txd_o   (txd_o)
	);
	spk_remote_node i_spk_remote_node (
		.ref_clk (ref_clk),
		.txd_o   (txd_o),
		.rxd_o   (rxd_o),
		.rxd_oe  (rxd_oe),
		.line_o  (line)
	);

	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	// Register port cycles: one-cycle strobes, read data taken in the cycle after the strobe.
	task automatic wr(input logic [7:0] a, input logic [7:0] w);
		@(posedge ref_clk);
		bus <= {a, w, 1'b1, 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [7:0] r);
		@(posedge ref_clk);
		bus <= {a, 8'h00, 1'b0, 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		r = rdata;
	endtask : rd

	// Writing the control register also clears both done flags in the model.
	task automatic set_ctl(input int md, input int f, input int r, input int t);
		mode = md;
		filt = f;
		ren = r;
		tb8 = t;
		m_ri = 0;
		m_ti = 0;
		wr(spk_pkg::SPK_CTL_ADDR, {md[1], md[0], f[0], r[0], t[0], m_rb8[0], 2'b00});
	endtask : set_ctl

	task automatic check_ctl(input int asel);
		logic [7:0] e;
		e = {asel ? m_fe[0] : mode[1], mode[0], filt[0], ren[0], tb8[0], m_rb8[0], m_ti[0], m_ri[0]};
		rd(spk_pkg::SPK_CTL_ADDR, v);
		chk(v, e, "control view");
	endtask : check_ctl

	// Receive model: a bad stop flags an error; the filter may drop the frame; accepted ones overwrite.
	task automatic model_rx(input logic [7:0] dat, input int nin, input int stp);
		if (ren && !stp)
			m_fe = 1;
		if (ren && !(filt && ((mode == 1) ? !stp : !nin))) begin
			q_rx.push_back(dat);
			m_ri = 1;
			m_rb8 = (mode == 1) ? stp : nin;
		end
	endtask : model_rx

	function automatic logic [10:0] frm(input logic [7:0] dat, input int md, input int nin, input int stp);
		return (md == 1) ? {1'b1, stp[0], dat, 1'b0} : {stp[0], nin[0], dat, 1'b0};
	endfunction : frm

	// Cuts a hung run short; it counts as a mismatch.
	initial begin
		repeat (100000) @(posedge ref_clk);
		mismatches++;
		$display("[FAIL] %0t run did not finish", $time);
		stop_test();
	end

	// Main sequence: reset view, asynchronous cases with overlapping transmit, then shift mode.
	initial begin
		repeat (20) @(posedge ref_clk);
		srst <= 1'b0;
		check_ctl(0);
		rd(spk_pkg::SPK_BUF_ADDR, v);
		chk(v, spk_pkg::SPK_BUF_RESET, "buffer after reset");
		wr(8'h55, 8'hff);
		rd(8'h55, v);
		chk(v, 8'h00, "unmapped read");
		$display("test reset done");
		for (int i = 0; i < 8; i++) begin
			wr(spk_pkg::SPK_PWR_ADDR, tab[i][5] ? 8'h80 : 8'h00);
			if (!tab[i][6])
				set_ctl(tab[i][0], tab[i][1], tab[i][2], $random(seed) & 1);
			d = $random(seed);
			v = $random(seed);
			fork
				i_spk_remote_node.send(frm(d, mode, tab[i][3], tab[i][4]), tab[i][5] ? 16 : 32);
				wr(spk_pkg::SPK_BUF_ADDR, v);
				i_spk_remote_node.grab(tab[i][5] ? 16 : 32, bits, ok);
			join
			chk(ok, 1'b1, "transmit start seen");
			chk(bits, frm(v, mode, tb8, 1), "transmit frame");
			m_ti = 1;
			model_rx(d, tab[i][3], tab[i][4]);
			wr(spk_pkg::SPK_PWR_ADDR, tab[i][5] ? 8'hc0 : 8'h40);
			check_ctl(1);
			rd(spk_pkg::SPK_BUF_ADDR, v);
			chk(v, q_rx[$], "received byte");
			$display("test async %0d done", i);
		end
		// With the error view selected, bit 7 writes clear the error flag and leave the mode alone.
		set_ctl(0, 0, 0, 0);
		mode = 2;
		m_fe = 0;
		check_ctl(1);
		wr(spk_pkg::SPK_PWR_ADDR, 8'h00);
		check_ctl(0);
		set_ctl(0, 0, 0, 0);
		d = $random(seed);
		fork
			wr(spk_pkg::SPK_BUF_ADDR, d);
			i_spk_remote_node.m0_grab(v, ok);
		join
		chk(ok, 1'b1, "shift clock seen");
		chk(v, d, "shift transmit byte");
		m_ti = 1;
		check_ctl(0);
		$display("test shift transmit done");
		set_ctl(0, 1, 1, 0);
		d = $random(seed);
		i_spk_remote_node.m0_send(d, ok);
		chk(ok, 1'b1, "shift receive clock seen");
		q_rx.push_back(d);
		m_ri = 1;
		check_ctl(0);
		rd(spk_pkg::SPK_BUF_ADDR, v);
		chk(v, q_rx[$], "shift received byte");
		$display("test shift receive done");
		stop_test();
	end
endmodule : spk_serial_port_tb

/* File: rtl/spk_pkg.sv */
// Package with the register map, field positions, counts and types of the four-mode serial port.
package spk_pkg;
	// Register byte addresses on the plain register port.
	localparam logic [7:0] SPK_CTL_ADDR = 8'h98;
	localparam logic [7:0] SPK_BUF_ADDR = 8'h99;
	localparam logic [7:0] SPK_PWR_ADDR = 8'h87;
	// Field positions in the serial control register.
	localparam int SPK_CTL_TOP  = 7;
	localparam int SPK_CTL_SM1  = 6;
	localparam int SPK_CTL_SM2  = 5;
	localparam int SPK_CTL_REN  = 4;
	localparam int SPK_CTL_TB8  = 3;
	localparam int SPK_CTL_RB8  = 2;
	localparam int SPK_CTL_TI   = 1;
	localparam int SPK_CTL_RI   = 0;
	// Field positions in the power control register.
	localparam int SPK_PWR_RATE = 7;
	localparam int SPK_PWR_FEAS = 6;
	// Values after reset.
	localparam logic [7:0] SPK_CTL_RESET = 8'h00;
	localparam logic [7:0] SPK_BUF_RESET = 8'h00;
	localparam logic       SPK_PWR_RESET = 1'b0;
	// Operating modes, coded as {mode_select_bit0, mode_select_bit1}.
	localparam logic [1:0] SPK_MODE_SHIFT = 2'h0;
	localparam logic [1:0] SPK_MODE_UART8 = 2'h1;
	localparam logic [1:0] SPK_MODE_FIX9  = 2'h2;
	localparam logic [1:0] SPK_MODE_VAR9  = 2'h3;
	// Cycle and tick counts.
	localparam logic [3:0] SPK_TICK_LAST = 4'hf;
	localparam logic [3:0] SPK_TICK_MID  = 4'h7;
	localparam logic [3:0] SPK_M0_LAST   = 4'hf;
	localparam logic [3:0] SPK_TX_STOP8  = 4'h9;
	localparam logic [3:0] SPK_TX_STOP9  = 4'ha;
	localparam logic [3:0] SPK_RX_STOP8  = 4'h8;
	localparam logic [3:0] SPK_RX_STOP9  = 4'h9;
	// Register port request.
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} spk_bus_type;
	// Transmit and receive sequencers.
	typedef enum logic [2:0] {
		SPK_TX_IDLE  = 3'b001,
		SPK_TX_SYNC  = 3'b010,
		SPK_TX_ASYNC = 3'b100
	} spk_tx_state_type;
	typedef enum logic [3:0] {
		SPK_RX_IDLE  = 4'b0001,
		SPK_RX_SYNC  = 4'b0010,
		SPK_RX_START = 4'b0100,
		SPK_RX_BITS  = 4'b1000
	} spk_rx_state_type;
endpackage : spk_pkg

/* File: rtl/spk_serial_port.sv */
// Four-mode serial port with shift-register mode, 8-bit and 9-bit asynchronous frames.
//
// Summary of operation
// (R1) Transmitter and receiver run independently; sending and receiving may overlap. Here mode 0 reception waits for an idle transmitter.
// (R2) Reception of a new frame may start while the last byte is unread; it overwrites.
// (R3) One buffer address: writes load the transmitter, reads return the receive holding register.
// (R4) Mode 0 moves eight bits LSB first on the data pin, shift clock at half rate.
// (R5) Mode 1 frame: start 0, eight data bits LSB first, stop 1.
// (R6) Mode 1 reception stores the received stop bit in received_ninth_bit.
// (R7) Modes 1 and 3 take bit timing from Timer 1 overflow events.
// (R8) Modes 2 and 3 send start, eight data bits, transmit_ninth_bit, stop.
// (R9) Modes 2 and 3 capture the ninth data bit into received_ninth_bit, not the stop.
// (R10) Mode 2 bit rate is one sixteenth or one thirty-second of the clock.
// (R11) Any buffer write starts a transmission in every mode.
// (R12) Mode 0 reception begins when rx_done_flag is 0 and receive enable is 1.
// (R13) Modes 1 to 3 reception begins on a start bit, only with receive enable set.
// (R14) Modes 2 and 3 with the filter set flag a frame only if its ninth bit is 1.
// (R15) The multiprocessor filter bit has no effect in mode 0.
// (R16) Mode 1 with the filter set flags a frame only with a valid stop bit.
// (R17) A remote master marks address bytes with ninth bit 1 and data bytes with 0.
// (R18) The control register sits at 98H and resets to all zeros.
// (R19) Any invalid stop bit sets framing_error_flag, which stays until software clears it.
// (R20) Control bit 7 shows framing_error_flag when access select is 1, else mode bit 0.
// (R21) tx_done_flag sets after eight shift bits or at stop start; software clears it.
// (R22) rx_done_flag sets after eight shift bits or mid stop, if filtering allows.
// (R23) frame_err_access_select is bit 6 of the power control register.
// (R24) Start edges are found on the oversampled tick and bits are sampled at centre.
// (R25) Timer 1 overflow arrives as a one-cycle pulse and is the variable-rate tick.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ns
module spk_serial_port (
	input  wire logic                ref_clk,
	input  wire logic                srst,
	input  wire spk_pkg::spk_bus_type bus,
	output logic [7:0]               rdata,
	input  wire logic                t1_ovf,
	input  wire logic                rxd_i,
	output logic                     rxd_o,
	output logic                     rxd_oe,
	output logic                     txd_o
);
	spk_pkg::spk_tx_state_type tx_state_r;
	spk_pkg::spk_rx_state_type rx_state_r; // R1
	logic        mode_select_bit0_r, mode_select_bit1_r, multiproc_filter_enable_r, rx_enable_r;
	logic        transmit_ninth_bit_r, received_ninth_bit_r, tx_done_flag_r, rx_done_flag_r;
	logic        framing_error_flag_r, frame_err_access_select_r, rate_double_r;
	logic [7:0]  rx_hold_r, rdata_r;
	logic [10:0] tx_sh_r;
	logic [3:0]  tx_cnt_r, tx_bit_r, rx_cnt_r, rx_bit_r;
	logic [8:0]  rx_sh_r;
	logic        sclk_r, oe_r, rx_prev_r, div_r;

	// Register port decoding.
	wire [1:0] mode     = {mode_select_bit0_r, mode_select_bit1_r};
	wire       wr_ctl   = bus.wr && (bus.addr == spk_pkg::SPK_CTL_ADDR);
	wire       wr_buf   = bus.wr && (bus.addr == spk_pkg::SPK_BUF_ADDR); // R3
	wire       wr_pwr   = bus.wr && (bus.addr == spk_pkg::SPK_PWR_ADDR);
	wire       rd_ctl   = bus.rd && (bus.addr == spk_pkg::SPK_CTL_ADDR);
	wire       rd_buf   = bus.rd && (bus.addr == spk_pkg::SPK_BUF_ADDR);
	wire       rd_pwr   = bus.rd && (bus.addr == spk_pkg::SPK_PWR_ADDR);
	wire       is_sync  = (mode == spk_pkg::SPK_MODE_SHIFT);
	wire       is_nine  = mode[1];

	// Oversample tick: sixteen per bit. Mode 2 divides the clock, the others follow Timer 1.
	wire os_tick = (mode == spk_pkg::SPK_MODE_FIX9) ? (rate_double_r | div_r) : t1_ovf; // R7 R10 R25

	// Top control bit is shared between the error flag and mode bit 0.
	wire top_bit = frame_err_access_select_r ? framing_error_flag_r : mode_select_bit0_r; // R20
	wire [7:0] ctl_view = {top_bit, mode_select_bit1_r, multiproc_filter_enable_r, rx_enable_r,
		transmit_ninth_bit_r, received_ninth_bit_r, tx_done_flag_r, rx_done_flag_r};

	// Transmit sequencing terms.
	wire [3:0] tx_stop  = is_nine ? spk_pkg::SPK_TX_STOP9 : spk_pkg::SPK_TX_STOP8;
	wire       tx_m0_end = (tx_state_r == spk_pkg::SPK_TX_SYNC) && (tx_cnt_r == spk_pkg::SPK_M0_LAST);
	wire       tx_bit_end = (tx_state_r == spk_pkg::SPK_TX_ASYNC) && os_tick &&
		(tx_cnt_r == spk_pkg::SPK_TICK_LAST);
	wire       tx_at_stop = tx_bit_end && (tx_bit_r + 4'h1 == tx_stop);
	wire       ti_set    = tx_m0_end || tx_at_stop; // R21
	// Nine-bit frames carry the ninth bit; eight-bit frames repeat the stop level there.
	wire [10:0] tx_frame = {1'b1, (is_nine ? transmit_ninth_bit_r : 1'b1), bus.wdata, 1'b0}; // R5 R8

	// Receive sequencing terms.
	wire [3:0] rx_stop   = is_nine ? spk_pkg::SPK_RX_STOP9 : spk_pkg::SPK_RX_STOP8;
	wire       rx_m0_go  = (rx_state_r == spk_pkg::SPK_RX_IDLE) && is_sync && !rx_done_flag_r &&
		rx_enable_r && (tx_state_r == spk_pkg::SPK_TX_IDLE) && !wr_buf; // R12 R15
	wire       rx_m0_end = (rx_state_r == spk_pkg::SPK_RX_SYNC) && (rx_cnt_r == spk_pkg::SPK_M0_LAST);
	wire       rx_edge   = (rx_state_r == spk_pkg::SPK_RX_IDLE) && !is_sync && rx_enable_r &&
		os_tick && rx_prev_r && !rxd_i; // R13 R24
	wire       rx_centre = (rx_state_r == spk_pkg::SPK_RX_BITS) && os_tick &&
		(rx_cnt_r == spk_pkg::SPK_TICK_LAST); // R24
	wire       rx_fin    = rx_centre && (rx_bit_r == rx_stop);
	wire       stop_ok   = rxd_i;
	wire       ninth_in  = rx_sh_r[8];
	// Filtering: mode 1 wants a good stop, modes 2 and 3 want an address ninth bit.
	wire       rx_accept = rx_fin && (!multiproc_filter_enable_r || (is_nine ? ninth_in : stop_ok)); // R14 R16
	wire [7:0] rx_data   = is_nine ? rx_sh_r[7:0] : rx_sh_r[8:1];
	wire       rx_load   = rx_accept || rx_m0_end; // R2
	wire       ri_set    = rx_load; // R22
	wire       fe_set    = rx_fin && !stop_ok; // R19

	// Output pins. Mode 0 turns the transmit pin into the shift clock.
	assign txd_o  = is_sync ? sclk_r : tx_sh_r[0];
	assign rxd_o  = tx_sh_r[0];
	assign rxd_oe = oe_r;
	assign rdata  = rdata_r;

	// Control register; hardware sets win over a software clear in the same cycle.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			{mode_select_bit0_r, mode_select_bit1_r, multiproc_filter_enable_r, rx_enable_r} <= 4'h0; // R18
			{transmit_ninth_bit_r, received_ninth_bit_r, tx_done_flag_r, rx_done_flag_r} <= 4'h0; // R18
			framing_error_flag_r <= spk_pkg::SPK_CTL_RESET[spk_pkg::SPK_CTL_TOP];
		end else begin
			if (wr_ctl) begin
				if (!frame_err_access_select_r) begin
					mode_select_bit0_r <= bus.wdata[spk_pkg::SPK_CTL_TOP]; // R20
				end
				mode_select_bit1_r        <= bus.wdata[spk_pkg::SPK_CTL_SM1];
				multiproc_filter_enable_r <= bus.wdata[spk_pkg::SPK_CTL_SM2];
				rx_enable_r               <= bus.wdata[spk_pkg::SPK_CTL_REN];
				transmit_ninth_bit_r      <= bus.wdata[spk_pkg::SPK_CTL_TB8];
			end
			if (rx_accept) begin
				received_ninth_bit_r <= is_nine ? ninth_in : stop_ok; // R6 R9
			end else if (wr_ctl) begin
				received_ninth_bit_r <= bus.wdata[spk_pkg::SPK_CTL_RB8];
			end
			tx_done_flag_r <= ti_set | (wr_ctl ? bus.wdata[spk_pkg::SPK_CTL_TI] : tx_done_flag_r); // R21
			rx_done_flag_r <= ri_set | (wr_ctl ? bus.wdata[spk_pkg::SPK_CTL_RI] : rx_done_flag_r); // R22
			framing_error_flag_r <= fe_set |
				((wr_ctl && frame_err_access_select_r) ? bus.wdata[spk_pkg::SPK_CTL_TOP] : framing_error_flag_r); // R19
		end
	end

	// Power control bits, receive holding register and read data for exactly one cycle.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			frame_err_access_select_r <= spk_pkg::SPK_PWR_RESET;
			rate_double_r             <= spk_pkg::SPK_PWR_RESET;
			rx_hold_r                 <= spk_pkg::SPK_BUF_RESET;
			rdata_r                   <= 8'h00;
		end else begin
			if (wr_pwr) begin
				frame_err_access_select_r <= bus.wdata[spk_pkg::SPK_PWR_FEAS]; // R23
				rate_double_r             <= bus.wdata[spk_pkg::SPK_PWR_RATE];
			end
			// The eighth shift-mode sample lands on the loading edge itself, so it comes straight from the pin.
			if (rx_load) begin
				rx_hold_r <= rx_m0_end ? {rxd_i, rx_sh_r[8:2]} : rx_data; // R2 R3
			end
			if (rd_ctl) begin
				rdata_r <= ctl_view;
			end else if (rd_buf) begin
				rdata_r <= rx_hold_r; // R3
			end else if (rd_pwr) begin
				rdata_r <= {rate_double_r, frame_err_access_select_r, 6'h00};
			end else begin
				rdata_r <= 8'h00;
			end
		end
	end

	// Clock divider for the slower mode 2 rate.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			div_r <= 1'b0;
		end else begin
			div_r <= ~div_r;
		end
	end

	// Transmitter. A write always restarts it, even mid-frame, so software must wait for tx_done_flag.
	// It also owns the shift clock pin, so a mode 0 reception borrows its clock from here.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_state_r <= spk_pkg::SPK_TX_IDLE;
			tx_sh_r    <= 11'h7ff;
			tx_cnt_r   <= 4'h0;
			tx_bit_r   <= 4'h0;
			sclk_r     <= 1'b1;
			oe_r       <= 1'b0;
		end else if (wr_buf) begin
			tx_cnt_r <= 4'h0;
			tx_bit_r <= 4'h0;
			if (is_sync) begin
				tx_state_r <= spk_pkg::SPK_TX_SYNC; // R11
				tx_sh_r    <= {3'h7, bus.wdata};
				sclk_r     <= 1'b0;
				oe_r       <= 1'b1;
			end else begin
				tx_state_r <= spk_pkg::SPK_TX_ASYNC; // R11
				tx_sh_r    <= tx_frame;
				oe_r       <= 1'b0;
			end
		end else if (tx_state_r == spk_pkg::SPK_TX_SYNC) begin
			tx_cnt_r <= tx_cnt_r + 4'h1;
			if (tx_m0_end) begin
				tx_state_r <= spk_pkg::SPK_TX_IDLE;
				tx_sh_r    <= 11'h7ff;
				sclk_r     <= 1'b1;
				oe_r       <= 1'b0;
			end else begin
				sclk_r <= ~sclk_r; // R4
				if (tx_cnt_r[0]) begin
					tx_sh_r <= {1'b1, tx_sh_r[10:1]}; // R4
				end
			end
		end else if (tx_state_r == spk_pkg::SPK_TX_ASYNC && os_tick) begin
			tx_cnt_r <= tx_cnt_r + 4'h1;
			if (tx_bit_end) begin
				if (tx_bit_r == tx_stop) begin
					tx_state_r <= spk_pkg::SPK_TX_IDLE;
				end else begin
					tx_sh_r  <= {1'b1, tx_sh_r[10:1]}; // R5 R8
					tx_bit_r <= tx_bit_r + 4'h1;
				end
			end
		end else if (rx_m0_go) begin
			sclk_r <= 1'b0; // R4
		end else if ((rx_state_r == spk_pkg::SPK_RX_SYNC) && (tx_state_r == spk_pkg::SPK_TX_IDLE)) begin
			sclk_r <= rx_m0_end ? 1'b1 : ~sclk_r; // R4
		end
	end

	// Receiver; it runs on its own state so it overlaps the transmitter in modes 1 to 3; in mode 0 it waits for an idle transmitter.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_state_r <= spk_pkg::SPK_RX_IDLE;
			rx_sh_r    <= 9'h000;
			rx_cnt_r   <= 4'h0;
			rx_bit_r   <= 4'h0;
			rx_prev_r  <= 1'b1;
		end else begin
			if (os_tick) begin
				rx_prev_r <= rxd_i;
			end
			case (rx_state_r)
				spk_pkg::SPK_RX_IDLE: begin
					rx_cnt_r <= 4'h0;
					rx_bit_r <= 4'h0;
					if (rx_m0_go) begin
						rx_state_r <= spk_pkg::SPK_RX_SYNC; // R12
					end else if (rx_edge) begin
						rx_state_r <= spk_pkg::SPK_RX_START; // R13
					end
				end
				spk_pkg::SPK_RX_SYNC: begin
					rx_cnt_r <= rx_cnt_r + 4'h1;
					if (tx_state_r != spk_pkg::SPK_TX_IDLE) begin
						rx_state_r <= spk_pkg::SPK_RX_IDLE;
					end else begin
						if (rx_cnt_r[0]) begin
							rx_sh_r <= {rxd_i, rx_sh_r[8:1]}; // R4
						end
						if (rx_m0_end) begin
							rx_state_r <= spk_pkg::SPK_RX_IDLE;
						end
					end
				end
				spk_pkg::SPK_RX_START: begin
					if (os_tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
						if (rx_cnt_r == spk_pkg::SPK_TICK_MID) begin
							rx_cnt_r   <= 4'h0;
							rx_state_r <= rxd_i ? spk_pkg::SPK_RX_IDLE : spk_pkg::SPK_RX_BITS; // R24
						end
					end
				end
				spk_pkg::SPK_RX_BITS: begin
					if (os_tick) begin
						rx_cnt_r <= rx_cnt_r + 4'h1;
					end
					if (rx_fin) begin
						rx_state_r <= spk_pkg::SPK_RX_IDLE;
					end else if (rx_centre) begin
						rx_sh_r  <= {rxd_i, rx_sh_r[8:1]}; // R5 R9
						rx_bit_r <= rx_bit_r + 4'h1;
					end
				end
				default: begin
					rx_state_r <= spk_pkg::SPK_RX_IDLE;
				end
			endcase
		end
	end

	// Checks on the behaviour above.
	sequence m0_write_s;
		wr_buf && is_sync;
	endsequence

	sequence m0_shifting_s;
		(tx_state_r == spk_pkg::SPK_TX_SYNC) && is_sync;
	endsequence

	write_starts_tx_a: assert property (@(posedge ref_clk) disable iff (srst) // R11
		wr_buf |=> (tx_state_r != spk_pkg::SPK_TX_IDLE))
		else $error("Buffer write did not start a transmission.");

	shift_clock_half_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
		m0_shifting_s ##1 m0_shifting_s |-> (txd_o != $past(txd_o)))
		else $error("Shift clock did not toggle every cycle.");

	m0_tx_done_a: assert property (@(posedge ref_clk) disable iff (srst) // R21
		m0_write_s ##1 (!wr_buf && !wr_ctl) [*8] ##1 (!wr_buf && !wr_ctl) [*8] |=> tx_done_flag_r)
		else $error("Mode 0 transmit flag missing after eight bits.");

	async_start_bit_a: assert property (@(posedge ref_clk) disable iff (srst) // R5
		(wr_buf && !is_sync) |=> (txd_o == 1'b0) && !rxd_oe)
		else $error("Asynchronous frame did not begin with a start bit.");

	fe_sticky_a: assert property (@(posedge ref_clk) disable iff (srst) // R19
		framing_error_flag_r && !(wr_ctl && frame_err_access_select_r) |=> framing_error_flag_r)
		else $error("Framing error flag dropped without a software clear.");

	rb8_stop_a: assert property (@(posedge ref_clk) disable iff (srst) // R6
		(rx_fin && (mode == spk_pkg::SPK_MODE_UART8) && !multiproc_filter_enable_r)
		|=> received_ninth_bit_r == $past(rxd_i))
		else $error("Mode 1 stop bit not stored in received_ninth_bit.");

	filter_ninth_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
		(rx_fin && is_nine && multiproc_filter_enable_r && !ninth_in && !wr_ctl)
		|=> $stable(rx_done_flag_r))
		else $error("Data frame raised the receive flag while filtering.");

	rx_needs_enable_a: assert property (@(posedge ref_clk) disable iff (srst) // R13
		(rx_state_r == spk_pkg::SPK_RX_IDLE) && !rx_enable_r |=> (rx_state_r == spk_pkg::SPK_RX_IDLE))
		else $error("Reception began with receive enable clear.");

	m0_rx_begin_a: assert property (@(posedge ref_clk) disable iff (srst) // R12
		rx_m0_go |=> (rx_state_r == spk_pkg::SPK_RX_SYNC) ##16 (rx_state_r == spk_pkg::SPK_RX_IDLE))
		else $error("Mode 0 reception did not run for sixteen cycles.");

	ri_set_wins_a: assert property (@(posedge ref_clk) disable iff (srst) // R22
		ri_set |=> rx_done_flag_r)
		else $error("Receive flag lost against a software clear.");

	slow_rate_a: assert property (@(posedge ref_clk) disable iff (srst) // R10
		((mode == spk_pkg::SPK_MODE_FIX9) && !rate_double_r && !wr_ctl && !wr_pwr && os_tick) |=> !os_tick)
		else $error("Mode 2 slow rate tick not halved.");

	// Shift-mode receive clock, flag timing, reset view and read-back.
	sequence m0_receiving_s;
		(rx_state_r == spk_pkg::SPK_RX_SYNC) && (tx_state_r == spk_pkg::SPK_TX_IDLE);
	endsequence

	m0_rx_clock_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
		m0_receiving_s ##1 m0_receiving_s |-> (txd_o != $past(txd_o)))
		else $error("Shift clock did not toggle during a mode 0 reception.");

	tx_done_stop_a: assert property (@(posedge ref_clk) disable iff (srst) // R21
		(!is_sync && $rose(tx_done_flag_r) && !$past(wr_ctl)) |-> txd_o)
		else $error("Transmit flag rose away from the start of the stop bit.");

	rx_done_mid_a: assert property (@(posedge ref_clk) disable iff (srst) // R22
		(!is_sync && $rose(rx_done_flag_r) && !$past(wr_ctl)) |-> $past(rx_fin))
		else $error("Receive flag rose away from the stop bit centre.");

	ctl_reset_a: assert property (@(posedge ref_clk) // R18
		srst |=> (ctl_view == spk_pkg::SPK_CTL_RESET))
		else $error("Control register not all zeros after reset.");

	m0_rx_flag_a: assert property (@(posedge ref_clk) disable iff (srst) // R15
		(rx_m0_end && (tx_state_r == spk_pkg::SPK_TX_IDLE)) |=> rx_done_flag_r)
		else $error("Mode 0 reception did not raise the receive flag.");

	fe_view_a: assert property (@(posedge ref_clk) disable iff (srst) // R20
		(rd_ctl && frame_err_access_select_r) |=> (rdata[spk_pkg::SPK_CTL_TOP] == $past(framing_error_flag_r)))
		else $error("Top control bit did not show the framing error flag.");

	buf_read_a: assert property (@(posedge ref_clk) disable iff (srst) // R3
		rd_buf |=> (rdata == $past(rx_hold_r)))
		else $error("Buffer read did not return the receive holding register.");
endmodule : spk_serial_port
